/* File: design/ofs_map.svh */
`ifndef OFS_MAP_SVH
`define OFS_MAP_SVH

// Register byte offsets
`define OFS_CTRL_OFS      4'h0
`define OFS_STATUS_OFS    4'h4
`define OFS_IRQ_STAT_OFS  4'h8
`define OFS_IRQ_MASK_OFS  4'hc

// Control fields
`define OFS_CTRL_MODE_LSB 0
`define OFS_CTRL_MODE_MSB 1
`define OFS_CTRL_RESET    2'h0

// Status and interrupt bit positions
`define OFS_EV_OV_CORE    0
`define OFS_EV_OV_AUX     1
`define OFS_EV_UV         2
`define OFS_EV_DISC       3
`define OFS_EV_OC         4
`define OFS_EV_PG_FALL    5
`define OFS_EV_W          6
`define OFS_ST_PG         6
`define OFS_ST_MASKED     7
`define OFS_ST_W          8

// Protection mask hold after a live transition, in clock cycles
`define OFS_MASK_CYC      5'h10

`endif

/* File: design/ofs_pkg.sv */
package ofs_pkg;

	typedef enum logic [1:0] {
		OFS_SERIAL,
		OFS_PARALLEL,
		OFS_FIXED
	} ofs_mode_e;

	typedef logic [1:0] ofs_pair_t;

endpackage : ofs_pkg

/* File: design/ofs_supervisor.sv */
// Functional notes
// - Overvoltage source: reference+250mV in serial/parallel, pin if host off, 1.8V fixed.
// - Overvoltage section: phase low, driver enable high, fault pin high, latched.
// - Other section on overvoltage: phase high impedance, driver enable low, latched.
// - Undervoltage at reference-400mV, armed above 500mV; latch both sections hiz, fault.
// - Power good is core AND aux flags in serial, core flag alone in parallel.
// - Section flag drops at reference-250mV; sections keep switching, power good low.
// - Power good held low until soft-start completes.
// - Power good masked while core is off and aux still runs.
// - Live transitions mask all but overcurrent, plus 16 cycles after their end.
// - Protections stay active during soft-start.
// - Core positive-sense disconnection (600mV) latches high impedance and fault.
// - Ground-loss amplifier difference over 500mV latches high impedance and fault.
// - Aux disconnection checks apply in serial mode only, same latched action.
// - Overcurrent acts like undervoltage; core checks per phase and total.
// - Overcurrent during a live transition still latches and disables.
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`include "ofs_map.svh"
`timescale 1ns/10ps
`default_nettype none

module ofs_supervisor (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [1:0]  pwm_in,
	input  wire logic [1:0]  ov_ref_cmp,
	input  wire logic [1:0]  ov_pin_cmp,
	input  wire logic [1:0]  ov_fix_cmp,
	input  wire logic [1:0]  uv_cmp,
	input  wire logic [1:0]  pg_low_cmp,
	input  wire logic [1:0]  pos_disc_cmp,
	input  wire logic [1:0]  neg_disc_cmp,
	input  wire logic [2:0]  oc_cmp,
	input  wire logic        ref_above_min,
	input  wire logic        live_voltage_transition,
	input  wire logic        soft_start_done,
	input  wire logic        core_off_cmd,
	input  wire logic        aux_running,
	input  wire logic        host_if_disable,
	output logic      [1:0]  phase_out,
	output logic      [1:0]  phase_oe,
	output logic      [1:0]  driver_enable,
	output logic             fault_out,
	output logic             power_ok_out,
	output logic             power_ok_oe,
	output logic             irq
);

	localparam int SW = 23;
	logic [SW-1:0] s1_reg;
	logic [SW-1:0] s2_reg;
	logic [SW-1:0] s3_reg;
	logic [SW-1:0] filt_reg;
	logic [SW-1:0] raw;
	logic [1:0]    ov_ref_f;
	logic [1:0]    ov_pin_f;
	logic [1:0]    ov_fix_f;
	logic [1:0]    uv_f;
	logic [1:0]    pg_low_f;
	logic [1:0]    pos_f;
	logic [1:0]    neg_f;
	logic [2:0]    oc_f;
	logic          ref_ok_f;
	logic          trans_f;
	logic          ss_done_f;
	logic          core_off_f;
	logic          aux_run_f;
	logic          host_dis_f;

	ofs_pkg::ofs_mode_e mode;
	logic [1:0]         ctrl_reg;
	logic [4:0]         mask_cnt_reg;
	logic               prot_mask;
	logic               serial;
	logic [1:0]         ov_sel;
	logic [1:0]         ov_det;
	logic               uv_det;
	logic               disc_det;
	logic               oc_det;
	logic [1:0]         ov_lat_reg;
	logic               uv_lat_reg;
	logic               disc_lat_reg;
	logic               oc_lat_reg;
	logic               hiz_lat;
	logic [1:0]         section_ok_flag;
	logic               pg_reg;
	logic               pg_next;
	logic               pg_freeze;
	logic [`OFS_EV_W-1:0] ev;
	logic [`OFS_EV_W-1:0] irq_stat_reg;
	logic [`OFS_EV_W-1:0] irq_mask_reg;
	logic [`OFS_EV_W-1:0] w1c;
	logic                 acc;
	logic                 wr_hit;
	logic [31:0]          rd_mux;

	function automatic logic [31:0] zx(input logic [7:0] v);
		return {24'h000000, v};
	endfunction : zx
	// Pins pass three flops; a change counts once stages 2 and 3 agree
	assign raw = {ov_ref_cmp, ov_pin_cmp, ov_fix_cmp, uv_cmp, pg_low_cmp,
		pos_disc_cmp, neg_disc_cmp, oc_cmp, ref_above_min,
		live_voltage_transition, soft_start_done, core_off_cmd,
		aux_running, host_if_disable};

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			filt_reg <= '0;
		end else begin
			s1_reg   <= raw;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= (s3_reg & ~(s2_reg ^ s3_reg))
				| (filt_reg & (s2_reg ^ s3_reg));
		end
	end

	assign {ov_ref_f, ov_pin_f, ov_fix_f, uv_f, pg_low_f, pos_f, neg_f, oc_f,
		ref_ok_f, trans_f, ss_done_f, core_off_f, aux_run_f,
		host_dis_f} = filt_reg;

	assign mode   = ofs_pkg::ofs_mode_e'(ctrl_reg);
	assign serial = (mode != ofs_pkg::OFS_PARALLEL);

	always_comb begin
		unique case (mode)
			ofs_pkg::OFS_SERIAL,
			ofs_pkg::OFS_PARALLEL: ov_sel = host_dis_f ? ov_pin_f : ov_ref_f;
			ofs_pkg::OFS_FIXED:    ov_sel = ov_fix_f;
			default:               ov_sel = ov_fix_f;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			mask_cnt_reg <= 5'h00;
		else if (trans_f)
			mask_cnt_reg <= `OFS_MASK_CYC;
		else if (mask_cnt_reg != 5'h00)
			mask_cnt_reg <= mask_cnt_reg - 5'h01;
	end

	assign prot_mask = trans_f || (mask_cnt_reg != 5'h00);

	assign uv_det = (|uv_f) && ref_ok_f && !prot_mask;
	assign ov_det = ov_sel & {2{!prot_mask}};
	assign disc_det = !prot_mask && (pos_f[0] || neg_f[0]
		|| (mode == ofs_pkg::OFS_SERIAL && (pos_f[1] || neg_f[1])));
	assign oc_det = |oc_f;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ov_lat_reg   <= 2'h0;
			uv_lat_reg   <= 1'b0;
			disc_lat_reg <= 1'b0;
			oc_lat_reg   <= 1'b0;
		end else begin
			ov_lat_reg   <= ov_lat_reg | ov_det;
			uv_lat_reg   <= uv_lat_reg | uv_det;
			disc_lat_reg <= disc_lat_reg | disc_det;
			oc_lat_reg   <= oc_lat_reg | oc_det;
		end
	end

	assign hiz_lat = uv_lat_reg || disc_lat_reg || oc_lat_reg;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			phase_out     <= 2'h0;
			phase_oe      <= 2'h0;
			driver_enable <= 2'h0;
			fault_out     <= 1'b0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (ov_lat_reg[i]) begin
					phase_out[i]     <= 1'b0;
					phase_oe[i]      <= 1'b1;
					driver_enable[i] <= 1'b1;
				end else if ((|ov_lat_reg) || hiz_lat) begin
					phase_out[i]     <= 1'b0;
					phase_oe[i]      <= 1'b0;
					driver_enable[i] <= 1'b0;
				end else begin
					phase_out[i]     <= pwm_in[i];
					phase_oe[i]      <= 1'b1;
					driver_enable[i] <= 1'b1;
				end
			end
			fault_out <= (|ov_lat_reg) || hiz_lat;
		end
	end

	assign section_ok_flag = ~pg_low_f;
	assign pg_freeze = prot_mask || (core_off_f && aux_run_f);

	always_comb begin
		if (!ss_done_f)
			pg_next = 1'b0;
		else if (pg_freeze)
			pg_next = pg_reg;
		else if (serial)
			pg_next = &section_ok_flag;
		else
			pg_next = section_ok_flag[0];
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pg_reg       <= 1'b0;
			power_ok_oe  <= 1'b1;
			power_ok_out <= 1'b0;
		end else begin
			pg_reg       <= pg_next;
			power_ok_oe  <= !pg_next;
			power_ok_out <= 1'b0;
		end
	end

	// Interrupt events and bus
	assign ev = {pg_reg && !pg_next, oc_det && !oc_lat_reg,
		disc_det && !disc_lat_reg, uv_det && !uv_lat_reg,
		ov_det & ~ov_lat_reg};
	assign acc    = (avs_read || avs_write) && avs_waitrequest;
	assign wr_hit = avs_write && !avs_waitrequest;
	assign w1c = (wr_hit && avs_address == `OFS_IRQ_STAT_OFS)
		? avs_writedata[`OFS_EV_W-1:0] : '0;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			irq_stat_reg <= '0;
		else
			irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg     <= `OFS_CTRL_RESET;
			irq_mask_reg <= '0;
		end else if (wr_hit) begin
			if (avs_address == `OFS_CTRL_OFS)
				ctrl_reg <= avs_writedata[`OFS_CTRL_MODE_MSB:`OFS_CTRL_MODE_LSB];
			if (avs_address == `OFS_IRQ_MASK_OFS)
				irq_mask_reg <= avs_writedata[`OFS_EV_W-1:0];
		end
	end

	always_comb begin
		unique case (avs_address)
			`OFS_CTRL_OFS:     rd_mux = zx({6'h00, ctrl_reg});
			`OFS_STATUS_OFS:   rd_mux = zx({prot_mask, pg_reg, 1'b0, oc_lat_reg,
				disc_lat_reg, uv_lat_reg, ov_lat_reg});
			`OFS_IRQ_STAT_OFS: rd_mux = zx({2'h0, irq_stat_reg});
			`OFS_IRQ_MASK_OFS: rd_mux = zx({2'h0, irq_mask_reg});
			default:           rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
			irq             <= 1'b0;
		end else begin
			avs_waitrequest <= !acc;
			if (acc && avs_read)
				avs_readdata <= rd_mux;
			irq <= |((irq_stat_reg | ev) & ~w1c & irq_mask_reg) || |(ev & irq_mask_reg);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_ov_fixed;
		mode == ofs_pkg::OFS_FIXED && ov_fix_f[0] && !prot_mask |=> ov_lat_reg[0];
	endproperty
	a_ov_fixed: assert property (p_ov_fixed) else $error("fixed ov missed");
	property p_ov_hold;
		ov_lat_reg[0] |=> phase_oe[0] && driver_enable[0] && !phase_out[0]
			&& fault_out;
	endproperty
	a_ov_hold: assert property (p_ov_hold) else $error("ov state wrong");
	property p_ov_other;
		ov_lat_reg == 2'h1 |=> !phase_oe[1] && !driver_enable[1];
	endproperty
	a_ov_other: assert property (p_ov_other) else $error("other not hiz");
	property p_uv;
		uv_det && ov_lat_reg == 2'h0 && ov_det == 2'h0
			|=> ##1 phase_oe == 2'h0 && fault_out;
	endproperty
	a_uv: assert property (p_uv) else $error("uv not hiz");
	property p_pg_par;
		mode == ofs_pkg::OFS_PARALLEL && ss_done_f && !pg_freeze
			|=> pg_reg == !$past(pg_low_f[0]);
	endproperty
	a_pg_par: assert property (p_pg_par) else $error("pg parallel");
	property p_pg_ss;
		!ss_done_f |=> power_ok_oe;
	endproperty
	a_pg_ss: assert property (p_pg_ss) else $error("pg before ss");
	property p_mask;
		$fell(trans_f) |-> mask_cnt_reg == `OFS_MASK_CYC ##15 prot_mask;
	endproperty
	a_mask: assert property (p_mask) else $error("mask hold wrong");
	property p_oc;
		oc_det |=> hiz_lat ##1 fault_out;
	endproperty
	a_oc: assert property (p_oc) else $error("oc not latched");
	property p_disc_aux;
		mode == ofs_pkg::OFS_PARALLEL && !pos_f[0] && !neg_f[0]
			&& !disc_lat_reg |=> !disc_lat_reg;
	endproperty
	a_disc_aux: assert property (p_disc_aux) else $error("aux disc");
	property p_latch;
		hiz_lat |=> hiz_lat;
	endproperty
	a_latch: assert property (p_latch) else $error("latch lost");

endmodule : ofs_supervisor

`default_nettype wire

/* File: dv/ofs_stage_model.sv */
`timescale 1ns/10ps
`default_nettype none

module ofs_stage_model (
	input  wire logic       ref_clk,
	input  wire logic [1:0] phase_out,
	input  wire logic [1:0] phase_oe,
	input  wire logic [1:0] driver_enable,
	input  wire logic       power_ok_oe,
	output logic      [1:0] phase_pin,
	output logic      [1:0] low_side_on,
	output logic            power_ok_pin
);
	logic [1:0] last_reg = 2'h0;

	// Released phase pin shows no stale level
	always @(posedge ref_clk) begin
		last_reg <= phase_pin;
	end
	assign phase_pin = (phase_oe & phase_out) | (~phase_oe & ~last_reg);
	// Low side conducts while enabled and driven low
	assign low_side_on = driver_enable & phase_oe & ~phase_pin;
	// Pull-up on the open-drain line
	assign power_ok_pin = ~power_ok_oe;
endmodule : ofs_stage_model

`default_nettype wire

/* File: dv/ofs_supervisor_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module ofs_supervisor_bench;
	logic        ref_clk, nrst, avs_read, avs_write, avs_waitrequest;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [1:0]  pwm_in, ov_ref_cmp, ov_pin_cmp, ov_fix_cmp, uv_cmp;
	logic [1:0]  pg_low_cmp, pos_disc_cmp, neg_disc_cmp, phase_out;
	logic [1:0]  phase_oe, driver_enable, phase_pin, low_side_on;
	logic [2:0]  oc_cmp;
	logic        ref_above_min, live_voltage_transition, soft_start_done;
	logic        core_off_cmd, aux_running, host_if_disable, fault_out;
	logic        power_ok_out, power_ok_oe, irq, power_ok_pin;
	integer      n_fail, comparisons, cycles, m_ov, m_hiz, i;
	integer      seed = 80;

	ofs_supervisor dut (.*);
	ofs_stage_model stage (.*);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		pwm_in <= $random(seed);
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail = n_fail + 1;
			test_done();
		end
	end

	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task wt(input integer n);
		repeat (n) @(posedge ref_clk);
	endtask : wt

	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task chk_out;
		if (m_ov != 0) begin
			check("phase_oe", phase_oe, m_ov); // section drive
			check("driver_en", driver_enable, m_ov); // enables
			check("low_side", low_side_on, m_ov); // low side on
		end else if (m_hiz != 0) begin
			check("hiz", {phase_oe, driver_enable}, 0); // both released
		end
		check("fault", fault_out, (m_ov != 0) || (m_hiz != 0)); // fault pin
		check("pok_out", power_ok_out, 0); // open drain only pulls low
	endtask : chk_out

	task do_reset;
		@(posedge ref_clk);
		nrst <= 1'b0;
		{ov_ref_cmp, ov_pin_cmp, ov_fix_cmp, uv_cmp, pos_disc_cmp,
			neg_disc_cmp, oc_cmp, live_voltage_transition,
			host_if_disable} <= '0;
		wt(3);
		nrst <= 1'b1;
		m_ov = 0;
		m_hiz = 0;
		wt(2);
		check("fault_clr", fault_out, 0); // cleared by reset
	endtask : do_reset

	task test_done;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	initial begin
		{nrst, avs_read, avs_write, avs_address, avs_writedata, pwm_in,
			ov_ref_cmp, ov_pin_cmp, ov_fix_cmp, uv_cmp, pg_low_cmp,
			pos_disc_cmp, neg_disc_cmp, oc_cmp, ref_above_min,
			live_voltage_transition, soft_start_done, core_off_cmd,
			aux_running, host_if_disable} = '0;
		{n_fail, comparisons, cycles, m_ov, m_hiz} = '0;
		wt(3);
		nrst <= 1'b1;
		bus(1'b0, 4'h0, 0);
		check("ctrl_rst", rd, 0);
		bus(1'b0, 4'h2, 0);
		check("unmapped", rd, 0);
		// Soft start: power good held, undervoltage armed by reference
		uv_cmp <= 2'h1;
		wt(8);
		check("pg_ss", power_ok_pin, 0); // held low in soft start
		chk_out(); // not armed below minimum
		ref_above_min <= 1'b1;
		wt(8);
		m_hiz = 1;
		chk_out(); // latched during soft start
		do_reset();
		// Power good forming, masking and its interrupt
		soft_start_done <= 1'b1;
		wt(8);
		check("pg_up", power_ok_pin, 1); // released
		pg_low_cmp <= 2'h2;
		wt(8);
		check("pg_ser", power_ok_pin, 0); // aux flag in serial
		check("irq_m", irq, 0); // Masked event
		chk_out(); // no fault on low flag
		bus(1'b1, 4'h0, 1);
		wt(8);
		check("pg_par", power_ok_pin, 1); // core alone in parallel
		bus(1'b1, 4'h0, 0);
		bus(1'b1, 4'hc, 32'h20);
		pg_low_cmp <= 2'h0;
		wt(8);
		pg_low_cmp <= 2'h1;
		wt(8);
		check("irq_on", irq, 1); // Power good fall event
		bus(1'b1, 4'h8, 32'h20);
		wt(3);
		check("irq_clr", irq, 0); // Write one clears
		pg_low_cmp <= 2'h0;
		wt(8);
		{core_off_cmd, aux_running} <= 2'h3;
		pg_low_cmp <= 2'h1;
		wt(8);
		check("pg_frz", power_ok_pin, 1); // masked while core off
		{core_off_cmd, aux_running, pg_low_cmp} <= '0;
		// Live transition masks overvoltage plus trailing cycles
		live_voltage_transition <= 1'b1;
		ov_ref_cmp <= 2'h1;
		wt(8);
		chk_out(); // masked in transition
		live_voltage_transition <= 1'b0;
		wt(12);
		chk_out(); // trailing mask
		wt(18);
		m_ov = 1;
		chk_out(); // unmasked later
		bus(1'b0, 4'h4, 0);
		check("st_ov", rd[0], 1); // Status of core overvoltage
		do_reset();
		// Overvoltage source by mode, each section
		for (i = 0; i < 3; i = i + 1) begin
			bus(1'b1, 4'h0, i);
			host_if_disable <= (i == 1);
			ov_ref_cmp <= (i == 0) ? 2'h0 : 2'h3;
			ov_pin_cmp <= (i == 1) ? 2'h0 : 2'h3;
			ov_fix_cmp <= (i == 2) ? 2'h0 : 2'h3;
			wt(8);
			chk_out(); // other sources ignored
			ov_ref_cmp <= (i == 0) ? 2'h1 << (i % 2) : 2'h0;
			ov_pin_cmp <= (i == 1) ? 2'h1 << (i % 2) : 2'h0;
			ov_fix_cmp <= (i == 2) ? 2'h1 << (i % 2) : 2'h0;
			wt(8);
			m_ov = 1 << (i % 2);
			chk_out(); // selected source
			do_reset();
		end
		// Overcurrent latches even in a live transition
		for (i = 0; i < 3; i = i + 1) begin
			live_voltage_transition <= 1'b1;
			oc_cmp <= 3'h1 << i;
			wt(8);
			m_hiz = 1;
			chk_out(); // every current check
			do_reset();
		end
		// Sense disconnection, aux only in serial mode
		for (i = 0; i < 4; i = i + 1) begin
			bus(1'b1, 4'h0, 1);
			pos_disc_cmp <= (i > 1) ? 2'h0 : 2'h1 << (i % 2);
			neg_disc_cmp <= (i > 1) ? 2'h1 << (i % 2) : 2'h0;
			wt(8);
			m_hiz = (i % 2 == 0);
			chk_out(); // parallel mode
			if (i % 2 == 1) begin
				bus(1'b1, 4'h0, 0);
				wt(8);
				m_hiz = 1;
				chk_out(); // aux checked in serial
			end
			do_reset();
		end
		test_done();
	end
endmodule : ofs_supervisor_bench

`default_nettype wire
